// >>> verilog/pin_port_pkg.sv
// Package: offsets, field layouts, reset values and carriers of the pin port
package pin_port_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int          PIN_COUNT   = 8;          // Pins of the port
   localparam int          WORD_BITS   = 16;         // Register width
   localparam int          ADDR_BITS   = 8;          // Register offset width
   localparam int          BE_BITS     = 2;          // Byte enables per word

   // ------------------------------------------------------------------
   // Offsets: memory-mapped control window and configuration space
   // ------------------------------------------------------------------
   localparam logic [7:0]  MEM_DIR_OFS = 8'h40;      // Direction, control window
   localparam logic [7:0]  MEM_DAT_OFS = 8'h42;      // Data, control window
   localparam logic [7:0]  CFG_DIR_OFS = 8'hb4;      // Direction, config space
   localparam logic [7:0]  CFG_DAT_OFS = 8'hb6;      // Data, config space

   // ------------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------------
   localparam int          LOW_LSB     = 0;          // Pin bits live in low byte
   localparam int          LOW_MSB     = 7;
   localparam int          LOW_LANE    = 0;          // Byte enable of the low byte
   localparam logic [7:0]  RSVD_READ   = 8'h00;      // Upper byte reads as zero
   localparam logic [7:0]  DIR_RESET   = 8'h00;      // All pins input
   localparam logic [7:0]  DRIVE_RESET = 8'h00;      // Drive latch after reset
   localparam logic [7:0]  SEC_CAPABLE = 8'h33;      // Pins 0, 1, 4, 5 share functions
   localparam logic [15:0] WORD_ZERO   = 16'h0000;   // Idle read data

   // Secondary function positions
   localparam int          SEC_CLKRUN  = 0;          // Clock-run on pin 0
   localparam int          SEC_PWROVR  = 1;          // power_override_function on pin 1
   localparam int          SEC_SCLK    = 2;          // Serial clock on pin 4
   localparam int          SEC_SDATA   = 3;          // Serial data on pin 5

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                 rd;                      // Read strobe, one cycle
      logic                 wr;                      // Write strobe, one cycle
      logic [7:0]           addr;                    // Register byte offset
      logic [1:0]           be;                      // Byte enables
      logic [15:0]          wdata;                   // Write data
   } reg_req_t;

   typedef struct packed {
      logic                 rvalid;                  // Read answer, one cycle
      logic [15:0]          rdata;                   // Read data
   } reg_rsp_t;

endpackage

// >>> verilog/bridge_gpio_port.sv
// Eight-pin general-purpose port with aliased direction and data registers
//
// Contract
// - Per-pin direction bit, 0 input, 1 output
// - Secondary-enabled pins ignore direction setting
// - Only pins 0,1,4,5 carry secondary functions
// - Data read returns sensed level for inputs
// - Data write drives output-mode free pins
// - Writes to input or secondary pins dropped
// - Bits 15:8 read zero, writes ignored
// - Link, global pin, power-on reset restore defaults
// - After reset data reads sensed levels
// - Direction register resets to all zeros
// - Direction register shared by both access paths
// - Data register shared by both access paths
`timescale 1ns/10ps

module bridge_gpio_port (
   // Clock and resets
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic                     link_reset,
   input  wire logic                     global_reset_pin_n,
   input  wire logic                     power_on_reset,
   // Memory-mapped control window access
   input  wire pin_port_pkg::reg_req_t   mem_req,
   output      pin_port_pkg::reg_rsp_t   mem_rsp,
   // Configuration space access
   input  wire pin_port_pkg::reg_req_t   cfg_req,
   output      pin_port_pkg::reg_rsp_t   cfg_rsp,
   // Secondary function enables: clk-run, power override, serial clk, data
   input  wire logic [3:0]               secondary_enable,
   // Port pins
   input  wire logic [7:0]               pin_in,
   output      logic [7:0]               pin_out,
   output      logic [7:0]               pin_oe
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   logic [7:0]  dir_r;                     // Direction bits
   logic [7:0]  drive_r;                   // Driven level latch
   logic [7:0]  sync1_r;                   // Pin synchroniser stage 1
   logic [7:0]  sync2_r;                   // Pin synchroniser stage 2
   logic [7:0]  sync3_r;                   // Pin synchroniser stage 3
   logic [7:0]  sense_r;                   // Filtered pin levels
   logic [2:0]  global_reset_pin_sync_r;               // Global reset pin synchroniser
   logic        global_reset_pin_r;                    // Filtered global reset, active high
   logic        port_reset;                // Any reset source
   logic [7:0]  sec_pins;                  // Pins claimed by secondary functions
   logic [7:0]  owned;                     // Output mode and not claimed
   logic [7:0]  data_view;                 // Data register read value
   logic        mem_dir_wr;                // Memory path writes direction
   logic        cfg_dir_wr;                // Config path writes direction
   logic        mem_dat_wr;                // Memory path writes data
   logic        cfg_dat_wr;                // Config path writes data

   // ------------------------------------------------------------------
   // Reset gathering
   // ------------------------------------------------------------------
   // Global reset pin through three flops, counts once stages 2, 3 agree
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         global_reset_pin_sync_r <= 3'h0;
      end else begin
         global_reset_pin_sync_r <= {global_reset_pin_sync_r[1:0], ~global_reset_pin_n};
      end
   end

   // Filtered global reset level
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         global_reset_pin_r <= 1'b0;
      end else if (global_reset_pin_sync_r[1] == global_reset_pin_sync_r[2]) begin
         global_reset_pin_r <= global_reset_pin_sync_r[2];
      end
   end

   // Every source restores the port defaults
   assign port_reset = rst | link_reset | global_reset_pin_r | power_on_reset;

   // ------------------------------------------------------------------
   // Pin sensing
   // ------------------------------------------------------------------
   // Three-flop input synchroniser
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
         sync3_r <= 8'h00;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Per-pin filter: level taken once stages 2 and 3 agree
   genvar gi;
   generate
      for (gi = 0; gi < pin_port_pkg::PIN_COUNT; gi++) begin : g_sense
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               sense_r[gi] <= 1'b0;
            end else if (sync2_r[gi] == sync3_r[gi]) begin
               sense_r[gi] <= sync3_r[gi];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // Ownership and pin drive
   // ------------------------------------------------------------------
   // Only pins 0, 1, 4, 5 can be claimed
   always_comb begin
      sec_pins      = 8'h00;
      sec_pins[0]   = secondary_enable[pin_port_pkg::SEC_CLKRUN];
      sec_pins[1]   = secondary_enable[pin_port_pkg::SEC_PWROVR];
      sec_pins[4]   = secondary_enable[pin_port_pkg::SEC_SCLK];
      sec_pins[5]   = secondary_enable[pin_port_pkg::SEC_SDATA];
   end

   // Claimed pins ignore direction; secondary logic drives them outside
   assign owned   = dir_r & ~sec_pins;
   assign pin_oe  = owned;
   assign pin_out = drive_r & owned;

   // Read view: sensed level for inputs, driven level for outputs
   assign data_view = (owned & drive_r) | (~owned & sense_r);

   // ------------------------------------------------------------------
   // Write decode, both paths reach the same registers
   // ------------------------------------------------------------------
   assign mem_dir_wr = mem_req.wr && mem_req.be[pin_port_pkg::LOW_LANE]
                       && (mem_req.addr == pin_port_pkg::MEM_DIR_OFS);
   assign cfg_dir_wr = cfg_req.wr && cfg_req.be[pin_port_pkg::LOW_LANE]
                       && (cfg_req.addr == pin_port_pkg::CFG_DIR_OFS);
   assign mem_dat_wr = mem_req.wr && mem_req.be[pin_port_pkg::LOW_LANE]
                       && (mem_req.addr == pin_port_pkg::MEM_DAT_OFS);
   assign cfg_dat_wr = cfg_req.wr && cfg_req.be[pin_port_pkg::LOW_LANE]
                       && (cfg_req.addr == pin_port_pkg::CFG_DAT_OFS);

   // Direction register; memory path wins a same-cycle clash
   always_ff @(posedge clk_sys) begin
      if (port_reset) begin
         dir_r <= pin_port_pkg::DIR_RESET;
      end else if (mem_dir_wr) begin
         dir_r <= mem_req.wdata[pin_port_pkg::LOW_MSB:pin_port_pkg::LOW_LSB];
      end else if (cfg_dir_wr) begin
         dir_r <= cfg_req.wdata[pin_port_pkg::LOW_MSB:pin_port_pkg::LOW_LSB];
      end
   end

   // Drive latch: only owned pins take written bits
   always_ff @(posedge clk_sys) begin
      if (port_reset) begin
         drive_r <= pin_port_pkg::DRIVE_RESET;
      end else if (mem_dat_wr) begin
         drive_r <= (drive_r & ~owned)
                  | (mem_req.wdata[pin_port_pkg::LOW_MSB:pin_port_pkg::LOW_LSB] & owned);
      end else if (cfg_dat_wr) begin
         drive_r <= (drive_r & ~owned)
                  | (cfg_req.wdata[pin_port_pkg::LOW_MSB:pin_port_pkg::LOW_LSB] & owned);
      end
   end

   // ------------------------------------------------------------------
   // Read answers, registered one cycle after the strobe
   // ------------------------------------------------------------------
   // Memory path read
   always_ff @(posedge clk_sys) begin
      if (port_reset) begin
         mem_rsp <= '0;
      end else begin
         mem_rsp.rvalid <= mem_req.rd;
         if (!mem_req.rd) begin
            mem_rsp.rdata <= pin_port_pkg::WORD_ZERO;
         end else if (mem_req.addr == pin_port_pkg::MEM_DIR_OFS) begin
            mem_rsp.rdata <= {pin_port_pkg::RSVD_READ, dir_r};
         end else if (mem_req.addr == pin_port_pkg::MEM_DAT_OFS) begin
            mem_rsp.rdata <= {pin_port_pkg::RSVD_READ, data_view};
         end else begin
            mem_rsp.rdata <= pin_port_pkg::WORD_ZERO;
         end
      end
   end

   // Configuration path read
   always_ff @(posedge clk_sys) begin
      if (port_reset) begin
         cfg_rsp <= '0;
      end else begin
         cfg_rsp.rvalid <= cfg_req.rd;
         if (!cfg_req.rd) begin
            cfg_rsp.rdata <= pin_port_pkg::WORD_ZERO;
         end else if (cfg_req.addr == pin_port_pkg::CFG_DIR_OFS) begin
            cfg_rsp.rdata <= {pin_port_pkg::RSVD_READ, dir_r};
         end else if (cfg_req.addr == pin_port_pkg::CFG_DAT_OFS) begin
            cfg_rsp.rdata <= {pin_port_pkg::RSVD_READ, data_view};
         end else begin
            cfg_rsp.rdata <= pin_port_pkg::WORD_ZERO;
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   // Any reset source leaves direction and drive at defaults
   dir_reset_a: assert property (@(posedge clk_sys)
      port_reset |=> (dir_r == pin_port_pkg::DIR_RESET)
                     && (drive_r == pin_port_pkg::DRIVE_RESET)
                     && (pin_oe == pin_port_pkg::DIR_RESET))
      else $error("port not at defaults after reset");

   // Upper byte always reads zero on both paths
   reserved_zero_a: assert property (@(posedge clk_sys) disable iff (port_reset)
      (mem_rsp.rdata[15:8] == pin_port_pkg::RSVD_READ)
      && (cfg_rsp.rdata[15:8] == pin_port_pkg::RSVD_READ))
      else $error("reserved byte not zero");

   // Direction write through config shows up in memory read
   sequence cfg_dir_write_s;
      cfg_dir_wr && !mem_dir_wr;
   endsequence
   sequence mem_dir_read_s;
      mem_req.rd && (mem_req.addr == pin_port_pkg::MEM_DIR_OFS);
   endsequence
   dir_alias_a: assert property (@(posedge clk_sys) disable iff (port_reset)
      cfg_dir_write_s ##1 (mem_dir_read_s and !mem_dir_wr && !cfg_dir_wr)
      |=> mem_rsp.rdata[7:0] == $past(cfg_req.wdata[7:0], 2))
      else $error("direction alias mismatch");

   // Owned pins take written bits, others keep theirs
   data_write_a: assert property (@(posedge clk_sys) disable iff (port_reset)
      mem_dat_wr |=> ((drive_r & $past(owned)) == ($past(mem_req.wdata[7:0]) & $past(owned)))
                  && ((drive_r & ~$past(owned)) == ($past(drive_r) & ~$past(owned))))
      else $error("data write mask wrong");

   // Config data write: owned pins take written bits
   cfg_data_write_a: assert property (@(posedge clk_sys) disable iff (port_reset)
      (cfg_dat_wr && !mem_dat_wr) |=>
         (drive_r & $past(owned)) == ($past(cfg_req.wdata[7:0]) & $past(owned)))
      else $error("config data write wrong");

   // Pin enable follows direction only on unclaimed pins
   pin_enable_a: assert property (@(posedge clk_sys) disable iff (port_reset)
      ((pin_oe & sec_pins) == 8'h00) && ((pin_oe | sec_pins) == (dir_r | sec_pins)))
      else $error("pin enable mismatch");

   // Only the four capable pins can be claimed
   sec_capable_a: assert property (@(posedge clk_sys)
      (sec_pins & ~pin_port_pkg::SEC_CAPABLE) == 8'h00)
      else $error("claim on incapable pin");

   // Data read returns sensed level for inputs, drive for outputs
   data_read_a: assert property (@(posedge clk_sys) disable iff (port_reset)
      (cfg_req.rd && (cfg_req.addr == pin_port_pkg::CFG_DAT_OFS)) |=>
         cfg_rsp.rvalid
         && ((cfg_rsp.rdata[7:0] & ~$past(owned)) == ($past(sense_r) & ~$past(owned)))
         && ((cfg_rsp.rdata[7:0] & $past(owned)) == ($past(drive_r) & $past(owned))))
      else $error("data read mismatch");

endmodule // bridge_gpio_port

// >>> tb/board_pins.sv
// Board-side model of the wires on the eight port pins
`timescale 1ns/10ps

module board_pins (
   // Port side
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   // Board drivers, seen on pins the port releases
   input  wire logic [7:0] board_level,
   // Resolved wire level
   output      logic [7:0] pin_in
);
   // Port drive wins where enabled, else the board driver sets the wire
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : board_level[i];
      end
   end
endmodule // board_pins

// >>> tb/tb.sv
// Self-checking bench of the pin port
`timescale 1ns/10ps

module tb;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic                   clk_sys;            // Bridge clock
   logic                   rst;                // Sync reset
   logic                   link_reset;         // Link reset
   logic                   global_reset_pin_n; // Global reset pin
   logic                   power_on_reset;     // Power-on reset
   pin_port_pkg::reg_req_t mem_req;            // Control window request
   pin_port_pkg::reg_rsp_t mem_rsp;            // Control window answer
   pin_port_pkg::reg_req_t cfg_req;            // Config request
   pin_port_pkg::reg_rsp_t cfg_rsp;            // Config answer
   logic [3:0]             secondary_enable;   // Function claims
   logic [7:0]             board_level;        // Board drivers
   logic [7:0]             pin_in;             // Wire levels
   logic [7:0]             pin_out;            // Port drive
   logic [7:0]             pin_oe;             // Port enable
   int                     fails;              // Mismatches
   int                     n_checks;           // Comparisons
   int                     pos[4] = '{0, 1, 4, 5}; // Claimed pin per function

   // Clock, 8 ns period
   always #4 clk_sys = ~clk_sys;

   bridge_gpio_port u_bridge_gpio_port (.clk_sys(clk_sys), .rst(rst),
      .link_reset(link_reset), .global_reset_pin_n(global_reset_pin_n),
      .power_on_reset(power_on_reset), .mem_req(mem_req), .mem_rsp(mem_rsp),
      .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .secondary_enable(secondary_enable),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

   board_pins u_board_pins (.pin_out(pin_out), .pin_oe(pin_oe),
      .board_level(board_level), .pin_in(pin_in));

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Compare and count
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask

   // One write strobe, held over one rising edge
   task automatic wr(bit cfg, logic [7:0] addr, logic [1:0] be, logic [15:0] d);
      pin_port_pkg::reg_req_t q;
      q = '0;
      q.wr = 1'b1;
      q.addr = addr;
      q.be = be;
      q.wdata = d;
      @(negedge clk_sys);
      if (cfg) cfg_req = q;
      else mem_req = q;
      @(negedge clk_sys);
      mem_req = '0;
      cfg_req = '0;
   endtask

   // One read strobe; answer sampled in the following cycle
   task automatic rd(bit cfg, logic [7:0] addr, logic [15:0] exp, string name);
      pin_port_pkg::reg_req_t q;
      pin_port_pkg::reg_rsp_t r;
      q = '0;
      q.rd = 1'b1;
      q.addr = addr;
      @(negedge clk_sys);
      if (cfg) cfg_req = q;
      else mem_req = q;
      @(negedge clk_sys);
      mem_req = '0;
      cfg_req = '0;
      r = cfg ? cfg_rsp : mem_rsp;
      check({name, " rvalid"}, 16'h0001, {15'h0000, r.rvalid});
      check(name, exp, r.rdata);
   endtask

   // Let pin levels pass the sense synchroniser
   task automatic settle();
      repeat (6) @(negedge clk_sys);
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Defaults after reset on both paths
   task automatic t_reset();
      settle();
      rd(0, pin_port_pkg::MEM_DIR_OFS, 16'h0000, "dir mem");
      rd(1, pin_port_pkg::CFG_DIR_OFS, 16'h0000, "dir cfg");
      check("pin_oe", 16'h0000, {8'h00, pin_oe});
      rd(0, pin_port_pkg::MEM_DAT_OFS, 16'h00a5, "data mem");
   endtask

   // Write through one path, read through the other
   task automatic t_alias();
      wr(0, pin_port_pkg::MEM_DIR_OFS, 2'h3, 16'ha5ff);
      rd(1, pin_port_pkg::CFG_DIR_OFS, 16'h00ff, "dir cfg");
      check("pin_oe", 16'h00ff, {8'h00, pin_oe});
      wr(1, pin_port_pkg::CFG_DAT_OFS, 2'h3, 16'h5a3c);
      rd(0, pin_port_pkg::MEM_DAT_OFS, 16'h003c, "data mem");
      check("pin_out", 16'h003c, {8'h00, pin_out});
   endtask

   // Half inputs, half outputs
   task automatic t_mixed();
      wr(0, pin_port_pkg::MEM_DIR_OFS, 2'h1, 16'h000f);
      board_level = 8'h50;
      wr(0, pin_port_pkg::MEM_DAT_OFS, 2'h1, 16'h00ff);
      settle();
      rd(1, pin_port_pkg::CFG_DAT_OFS, 16'h005f, "data mixed");
      check("pin_out mixed", 16'h000f, {8'h00, pin_out});
      wr(0, pin_port_pkg::MEM_DIR_OFS, 2'h1, 16'h00ff);
      check("pin_out all out", 16'h003f, {8'h00, pin_out});
   endtask

   // Each function claim frees its own pin only
   task automatic t_secondary();
      for (int i = 0; i < 4; i++) begin
         secondary_enable = 4'h1 << i;
         @(negedge clk_sys);
         check("pin_oe claim", {8'h00, 8'hff & ~(8'h01 << pos[i])}, {8'h00, pin_oe});
      end
      secondary_enable = 4'hf;
      wr(0, pin_port_pkg::MEM_DAT_OFS, 2'h1, 16'h0000);
      check("pin_out claimed", 16'h0000, {8'h00, pin_out});
      secondary_enable = 4'h0;
      @(negedge clk_sys);
      check("pin_out freed", 16'h0033, {8'h00, pin_out});
   endtask

   // Unmapped offset and missing low lane change nothing
   task automatic t_refused();
      rd(0, 8'h44, 16'h0000, "unmapped");
      wr(0, pin_port_pkg::MEM_DIR_OFS, 2'h2, 16'h0000);
      wr(1, 8'h44, 2'h3, 16'h0000);
      rd(1, pin_port_pkg::CFG_DIR_OFS, 16'h00ff, "dir kept");
   endtask

   // Config direction write, control-window read in the very next cycle
   task automatic t_alias_back();
      pin_port_pkg::reg_req_t q;
      q = '0;
      q.wr = 1'b1;
      q.addr = pin_port_pkg::CFG_DIR_OFS;
      q.be = 2'h1;
      q.wdata = 16'h005a;
      @(negedge clk_sys);
      cfg_req = q;
      q = '0;
      q.rd = 1'b1;
      q.addr = pin_port_pkg::MEM_DIR_OFS;
      @(negedge clk_sys);
      cfg_req = '0;
      mem_req = q;
      @(negedge clk_sys);
      mem_req = '0;
      check("dir back to back", 16'h005a, mem_rsp.rdata);
      check("rvalid back to back", 16'h0001, {15'h0000, mem_rsp.rvalid});
   endtask

   // Link, power-on and global pin resets each restore defaults
   task automatic t_resets();
      for (int k = 0; k < 3; k++) begin
         wr(0, pin_port_pkg::MEM_DIR_OFS, 2'h1, 16'h00ff);
         if (k == 0) link_reset = 1'b1;
         else if (k == 1) power_on_reset = 1'b1;
         else global_reset_pin_n = 1'b0;
         settle();
         link_reset = 1'b0;
         power_on_reset = 1'b0;
         global_reset_pin_n = 1'b1;
         settle();
         rd(0, pin_port_pkg::MEM_DIR_OFS, 16'h0000, "dir after reset");
         check("pin_oe after reset", 16'h0000, {8'h00, pin_oe});
      end
   endtask

   // Verdict and end of run
   task automatic summarize();
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      link_reset = 1'b0;
      global_reset_pin_n = 1'b1;
      power_on_reset = 1'b0;
      mem_req = '0;
      cfg_req = '0;
      secondary_enable = 4'h0;
      board_level = 8'ha5;
      fails = 0;
      n_checks = 0;
      repeat (4) @(negedge clk_sys);
      rst = 1'b0;
      t_reset();
      t_alias();
      t_mixed();
      t_secondary();
      t_refused();
      t_alias_back();
      t_resets();
      summarize();
   end

   // Watchdog, far beyond the roughly 104 cycles needed
   initial begin
      #160000;
      fails++;
      summarize();
   end
endmodule // tb
